/* ohci_regs_pkg.sv */
package ohci_regs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int REG_ADDR_W = 8;
    localparam logic [7:0] OFF_UID_LOW = 8'h28;
    localparam logic [7:0] OFF_ROM_MAP = 8'h34;
    localparam logic [7:0] OFF_FAIL_LOW = 8'h38;
    localparam logic [7:0] OFF_FAIL_HIGH = 8'h3C;
    localparam logic [7:0] OFF_VENDOR = 8'h40;
    localparam logic [7:0] OFF_CTRL_SET = 8'h50;
    localparam logic [7:0] OFF_CTRL_CLR = 8'h54;
    localparam logic [7:0] OFF_BUF_PTR = 8'h64;
    localparam logic [7:0] OFF_TALLY = 8'h68;
    localparam logic [7:0] OFF_CHAN_SET = 8'h70;
    localparam logic [7:0] OFF_CHAN_CLR = 8'h74;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int BIT_IMAGE_VALID = 31;
    localparam int BIT_SWAP_INHIBIT = 30;
    localparam int BIT_DELAYED_ACK = 29;
    localparam int BIT_ENH_OWNER = 23;
    localparam int BIT_ENH_ENABLE = 22;
    localparam int BIT_PHY_POWER = 19;
    localparam int BIT_EARLY_WRITE = 18;
    localparam int BIT_NODE_ACTIVE = 17;
    localparam int BIT_SELF_REINIT = 16;
    localparam logic [31:0] CTRL_SC_MASK = 32'hE04E_0000;
    localparam logic [31:0] ROM_MAP_MASK = 32'hFFFF_FC00;
    localparam logic [31:0] BUF_PTR_MASK = 32'hFFFF_F800;
    localparam int ROM_OFS_BITS = 10;
    localparam logic [47:0] ROM_WINDOW_START = 48'hFFFF_F000_0400;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] VENDOR_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SELF_REINIT_NS = 100;
    localparam int SELF_REINIT_CYCLES =
        (SELF_REINIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [REG_ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [31:0] mask;
    } reg_write_t;

    typedef struct packed {
        logic [15:0] requester;
        logic [47:0] dest;
    } posted_fail_t;

    typedef struct packed {
        logic fault;
        logic [8:0] quadlets;
    } self_id_result_t;

endpackage

/* axi_lite_reg_port.sv */
`timescale 1ns/10ps
module axi_lite_reg_port
    import ohci_regs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [REG_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output reg_write_t regWrite,
    output logic writeStrobe,
    input wire logic writeOk,
    output logic [REG_ADDR_W-1:0] readAddr,
    output logic readStrobe,
    input wire logic [31:0] readData,
    input wire logic readOk
);

    logic awHeld_reg;
    logic wHeld_reg;
    logic [REG_ADDR_W-1:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [31:0] byteMask;

    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    // Address and data may arrive in either order; each is parked
    assign s_axi_awready = !awHeld_reg && !bvalid_reg;
    assign s_axi_wready = !wHeld_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : gLane
            assign byteMask[8*i +: 8] = {8{wStrb_reg[i]}};
        end
    endgenerate

    assign writeStrobe = awHeld_reg && wHeld_reg;
    assign regWrite = '{addr: awAddr_reg, data: wData_reg, mask: byteMask};
    assign readStrobe = s_axi_arvalid && !rvalid_reg;
    assign readAddr = s_axi_araddr;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= ZERO_WORD;
            wStrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (writeStrobe) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= writeOk ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= ZERO_WORD;
        end else if (readStrobe) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= readOk ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= readData;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule

/* ohci_host_control_registers.sv */
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module ohci_host_control_registers
    import ohci_regs_pkg::*;
#(
    parameter int SELF_REINIT_LEN = SELF_REINIT_CYCLES,
    parameter logic OWNER_DEFAULT = 1'b1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [REG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [REG_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic romQuadReq,
    input wire logic [47:0] romQuadOffset,
    output logic romHostAddrValid,
    output logic [31:0] romHostAddr,
    input wire logic romBlockReq,
    output logic romBlockServe,
    output logic romBlockTypeError,
    output logic romAutoUpdateEnable,
    input wire logic postedFailValid,
    input wire posted_fail_t postedFail,
    input wire logic busResetSeen,
    input wire logic selfIdDone,
    input wire self_id_result_t selfIdResult,
    input wire logic pciOwnerLoad,
    input wire logic pciOwnerValue,
    input wire logic pciUidWrite,
    input wire logic [31:0] pciUidValue,
    output logic swapEnable,
    output logic delayedAckPermit,
    output logic enhancementOwner,
    output logic enhancementEnable,
    output logic phyPowerRequest,
    output logic earlyWriteAccept,
    output logic nodeActive,
    output logic softResetActive,
    output logic [31:0] nodeIdBufferAddr,
    output logic [31:0] upperChannelEnable,
    output logic [31:0] uniqueIdLow
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (SELF_REINIT_LEN < 1 || SELF_REINIT_LEN > 255) begin : gBadLen
        $error("SELF_REINIT_LEN must be 1 to 255");
    end

    localparam logic [7:0] REINIT_LOAD = 8'(SELF_REINIT_LEN);

    // ------------------------------------------------------------
    // Bus port
    // ------------------------------------------------------------
    reg_write_t regWrite;
    logic writeStrobe;
    logic writeOk;
    logic [REG_ADDR_W-1:0] readAddr;
    logic readStrobe;
    logic [31:0] readData;
    logic readOk;

    axi_lite_reg_port i_axi_lite_reg_port (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .regWrite(regWrite),
        .writeStrobe(writeStrobe),
        .writeOk(writeOk),
        .readAddr(readAddr),
        .readStrobe(readStrobe),
        .readData(readData),
        .readOk(readOk)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] ctrlFlags_reg;
    logic [31:0] ctrlFlags_next;
    logic owner_reg;
    logic [7:0] reinitCount_reg;
    logic [31:0] romMap_reg;
    logic [31:0] failLow_reg;
    logic [31:0] failHigh_reg;
    logic [31:0] bufPtr_reg;
    logic fault_reg;
    logic [7:0] generation_reg;
    logic [8:0] quadlets_reg;
    logic [31:0] chanMask_reg;
    logic [31:0] uid_reg;
    logic uidLoaded_reg;
    logic romAddrValid_reg;
    logic [31:0] romAddr_reg;
    logic romServe_reg;
    logic romTypeError_reg;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    logic [31:0] wrBits;
    logic [31:0] wrMask;
    logic wrCtrlSet;
    logic wrCtrlClr;
    logic wrRomMap;
    logic wrBufPtr;
    logic wrChanSet;
    logic wrChanClr;
    logic wrReadOnly;
    logic reinitBusy;
    logic stateReset;
    logic enhSetAllowed;
    logic [31:0] ctrlSetBits;
    logic [31:0] ctrlClrBits;

    assign wrBits = regWrite.data & regWrite.mask;
    assign wrMask = regWrite.mask;
    assign wrCtrlSet = writeStrobe && regWrite.addr == OFF_CTRL_SET;
    assign wrCtrlClr = writeStrobe && regWrite.addr == OFF_CTRL_CLR;
    assign wrRomMap = writeStrobe && regWrite.addr == OFF_ROM_MAP;
    assign wrBufPtr = writeStrobe && regWrite.addr == OFF_BUF_PTR;
    assign wrChanSet = writeStrobe && regWrite.addr == OFF_CHAN_SET;
    assign wrChanClr = writeStrobe && regWrite.addr == OFF_CHAN_CLR;
    assign wrReadOnly = regWrite.addr == OFF_UID_LOW
        || regWrite.addr == OFF_FAIL_LOW
        || regWrite.addr == OFF_FAIL_HIGH
        || regWrite.addr == OFF_VENDOR
        || regWrite.addr == OFF_TALLY;
    assign writeOk = wrCtrlSet || wrCtrlClr || wrRomMap || wrBufPtr
        || wrChanSet || wrChanClr || wrReadOnly;

    // ------------------------------------------------------------
    // Controller flags
    // ------------------------------------------------------------
    // Enhancement enable may only be raised while lower software has
    // handed ownership over and the node is still detached
    assign enhSetAllowed = owner_reg && !ctrlFlags_reg[BIT_NODE_ACTIVE];
    assign ctrlSetBits = wrCtrlSet
        ? (wrBits & CTRL_SC_MASK
           & ~(enhSetAllowed ? 32'h0000_0000 : 32'h0040_0000))
        : 32'h0000_0000;
    assign ctrlClrBits = wrCtrlClr ? (wrBits & CTRL_SC_MASK) : 32'h0000_0000;
    assign ctrlFlags_next = (ctrlFlags_reg & ~ctrlClrBits) | ctrlSetBits;

    // Whole-block reinit holds all register state except PCI-loaded state; the bus port keeps running
    assign reinitBusy = reinitCount_reg != 8'h00;
    assign stateReset = sys_rst || reinitBusy;

    always_ff @(posedge ref_clk) begin
        if (stateReset) begin
            ctrlFlags_reg <= CTRL_RESET;
        end else begin
            ctrlFlags_reg <= ctrlFlags_next & CTRL_SC_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reinitCount_reg <= 8'h00;
        end else if (wrCtrlSet && wrBits[BIT_SELF_REINIT] && !reinitBusy) begin
            reinitCount_reg <= REINIT_LOAD;
        end else if (reinitBusy) begin
            reinitCount_reg <= reinitCount_reg - 8'h01;
        end
    end

    // PCI load beats a same-cycle software clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            owner_reg <= OWNER_DEFAULT;
        end else if (pciOwnerLoad) begin
            owner_reg <= pciOwnerValue;
        end else if (wrCtrlClr && wrBits[BIT_ENH_OWNER]) begin
            owner_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pointer registers and channel mask
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (stateReset) begin
            romMap_reg <= ZERO_WORD;
            bufPtr_reg <= ZERO_WORD;
            chanMask_reg <= ZERO_WORD;
        end else begin
            if (wrRomMap) begin
                romMap_reg <= ((romMap_reg & ~wrMask) | wrBits) & ROM_MAP_MASK;
            end
            if (wrBufPtr) begin
                bufPtr_reg <= ((bufPtr_reg & ~wrMask) | wrBits) & BUF_PTR_MASK;
            end
            if (wrChanSet) begin
                chanMask_reg <= chanMask_reg | wrBits;
            end else if (wrChanClr) begin
                chanMask_reg <= chanMask_reg & ~wrBits;
            end
        end
    end

    // ------------------------------------------------------------
    // Posted write failure capture
    // ------------------------------------------------------------
    // A second failure overwrites the first; software reads promptly
    always_ff @(posedge ref_clk) begin
        if (stateReset) begin
            failLow_reg <= ZERO_WORD;
            failHigh_reg <= ZERO_WORD;
        end else if (postedFailValid) begin
            failLow_reg <= postedFail.dest[31:0];
            failHigh_reg <= {postedFail.requester, postedFail.dest[47:32]};
        end
    end

    // ------------------------------------------------------------
    // Self-identification tally
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (stateReset) begin
            fault_reg <= 1'b0;
            generation_reg <= 8'h00;
            quadlets_reg <= 9'h000;
        end else begin
            if (busResetSeen) begin
                generation_reg <= generation_reg + 8'h01;
            end
            if (selfIdDone) begin
                fault_reg <= selfIdResult.fault;
                quadlets_reg <= selfIdResult.quadlets;
            end
        end
    end

    // ------------------------------------------------------------
    // Unique identifier, low word
    // ------------------------------------------------------------
    // Only a full power reset re-arms the single load
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            uid_reg <= ZERO_WORD;
            uidLoaded_reg <= 1'b0;
        end else if (pciUidWrite && !uidLoaded_reg) begin
            uid_reg <= pciUidValue;
            uidLoaded_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Configuration ROM requests
    // ------------------------------------------------------------
    logic romInWindow;
    logic nodeUp;
    logic [31:0] romSum;

    assign nodeUp = ctrlFlags_reg[BIT_NODE_ACTIVE];
    assign romInWindow = romQuadOffset[47:ROM_OFS_BITS]
        == ROM_WINDOW_START[47:ROM_OFS_BITS];
    assign romSum = (romMap_reg & ROM_MAP_MASK)
        + {22'h000000, romQuadOffset[ROM_OFS_BITS-1:0]};

    // Detached node ignores all incoming requests
    always_ff @(posedge ref_clk) begin
        if (stateReset) begin
            romAddrValid_reg <= 1'b0;
            romAddr_reg <= ZERO_WORD;
            romServe_reg <= 1'b0;
            romTypeError_reg <= 1'b0;
        end else begin
            romAddrValid_reg <= romQuadReq && romInWindow && nodeUp;
            if (romQuadReq && romInWindow && nodeUp) begin
                romAddr_reg <= romSum;
            end
            romServe_reg <= romBlockReq && nodeUp
                && ctrlFlags_reg[BIT_IMAGE_VALID];
            romTypeError_reg <= romBlockReq && nodeUp
                && !ctrlFlags_reg[BIT_IMAGE_VALID];
        end
    end

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    logic [31:0] ctrlView;
    logic [31:0] tallyView;
    logic rdCtrl;
    logic rdChan;

    assign ctrlView = (ctrlFlags_reg & CTRL_SC_MASK)
        | {8'h00, owner_reg, 7'h00, 16'h0000}
        | {15'h0000, reinitBusy, 16'h0000};
    assign tallyView = {fault_reg, 7'h00, generation_reg, 5'h00,
        quadlets_reg, 2'h0};
    assign rdCtrl = readAddr == OFF_CTRL_SET || readAddr == OFF_CTRL_CLR;
    assign rdChan = readAddr == OFF_CHAN_SET || readAddr == OFF_CHAN_CLR;

    assign readData =
        rdCtrl ? ctrlView :
        rdChan ? chanMask_reg :
        readAddr == OFF_ROM_MAP ? romMap_reg :
        readAddr == OFF_FAIL_LOW ? failLow_reg :
        readAddr == OFF_FAIL_HIGH ? failHigh_reg :
        readAddr == OFF_VENDOR ? VENDOR_WORD :
        readAddr == OFF_BUF_PTR ? bufPtr_reg :
        readAddr == OFF_TALLY ? tallyView :
        readAddr == OFF_UID_LOW ? uid_reg :
        ZERO_WORD;
    assign readOk = rdCtrl || rdChan
        || readAddr == OFF_ROM_MAP
        || readAddr == OFF_FAIL_LOW
        || readAddr == OFF_FAIL_HIGH
        || readAddr == OFF_VENDOR
        || readAddr == OFF_BUF_PTR
        || readAddr == OFF_TALLY
        || readAddr == OFF_UID_LOW;

    // ------------------------------------------------------------
    // Outputs to link and PHY
    // ------------------------------------------------------------
    assign romHostAddrValid = romAddrValid_reg;
    assign romHostAddr = romAddr_reg;
    assign romBlockServe = romServe_reg;
    assign romBlockTypeError = romTypeError_reg;
    assign romAutoUpdateEnable = ctrlFlags_reg[BIT_IMAGE_VALID];
    assign swapEnable = !ctrlFlags_reg[BIT_SWAP_INHIBIT];
    assign delayedAckPermit = ctrlFlags_reg[BIT_DELAYED_ACK] && nodeUp;
    assign enhancementOwner = owner_reg;
    assign enhancementEnable = ctrlFlags_reg[BIT_ENH_ENABLE];
    assign phyPowerRequest = ctrlFlags_reg[BIT_PHY_POWER];
    assign earlyWriteAccept = ctrlFlags_reg[BIT_EARLY_WRITE];
    assign nodeActive = nodeUp;
    assign softResetActive = reinitBusy;
    assign nodeIdBufferAddr = bufPtr_reg;
    assign upperChannelEnable = chanMask_reg;
    assign uniqueIdLow = uid_reg;

endmodule

/* ohci_host_control_registers_monitor.sv */
`timescale 1ns/10ps
module ohci_host_control_registers_monitor
    import ohci_regs_pkg::*;
#(
    parameter int SELF_REINIT_LEN = SELF_REINIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic romQuadReq,
    input wire logic [47:0] romQuadOffset,
    input wire logic romHostAddrValid,
    input wire logic [31:0] romHostAddr,
    input wire logic romBlockReq,
    input wire logic romBlockServe,
    input wire logic romBlockTypeError,
    input wire logic romAutoUpdateEnable,
    input wire logic nodeActive,
    input wire logic softResetActive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] busyCnt;
    wire romHit = romQuadReq && nodeActive && romQuadOffset[47:10] == ROM_WINDOW_START[47:10];
    wire blk = romBlockReq && nodeActive;
    // Counts busy cycles so the length check needs no long repetition
    always_ff @(posedge ref_clk) begin
        busyCnt <= (sys_rst || !softResetActive) ? 8'h00 : busyCnt + 8'h01;
    end
    AST_ROM_ADDR: assert property (romHit |=> romHostAddrValid &&
        romHostAddr[9:0] == $past(romQuadOffset[9:0])) else $error("bad rom address");
    AST_ROM_SPUR: assert property (romHostAddrValid |-> $past(romQuadReq))
        else $error("rom answer without request");
    AST_ROM_GATE: assert property (romQuadReq && !nodeActive |=> !romHostAddrValid)
        else $error("rom answer while inactive");
    AST_BLK_SERVE: assert property (blk && romAutoUpdateEnable |=>
        romBlockServe && !romBlockTypeError) else $error("block read not served");
    AST_BLK_ERR: assert property (blk && !romAutoUpdateEnable |=>
        romBlockTypeError && !romBlockServe) else $error("block read not refused");
    AST_RST_NODE: assert property ($fell(sys_rst) |-> !nodeActive)
        else $error("node active after reset");
    AST_REINIT_LEN: assert property ($fell(softResetActive) |-> busyCnt == SELF_REINIT_LEN)
        else $error("reinit length wrong");
    AST_REINIT_QUIET: assert property (softResetActive |=> !nodeActive && !romAutoUpdateEnable)
        else $error("flags kept during reinit");
endmodule
bind ohci_host_control_registers ohci_host_control_registers_monitor #(
    .SELF_REINIT_LEN(SELF_REINIT_LEN)) i_ohci_host_control_registers_monitor (.*);

/* ohci_host_control_registers_tb_top.sv */
`timescale 1ns/10ps
module ohci_host_control_registers_tb_top
    import ohci_regs_pkg::*;
;
    logic ref_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, romQuadReq;
    logic romHostAddrValid, romBlockReq, romBlockServe, romBlockTypeError, romAutoUpdateEnable;
    logic postedFailValid, busResetSeen, selfIdDone, pciOwnerLoad, pciOwnerValue, pciUidWrite;
    logic swapEnable, delayedAckPermit, enhancementOwner, enhancementEnable, phyPowerRequest;
    logic earlyWriteAccept, nodeActive, softResetActive;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, pciUidValue, romHostAddr, nodeIdBufferAddr, rdVal;
    logic [31:0] upperChannelEnable, uniqueIdLow;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rdResp;
    logic [47:0] romQuadOffset;
    posted_fail_t postedFail;
    self_id_result_t selfIdResult;
    int errTotal = 0;
    int checked = 0;
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    ohci_host_control_registers #(.SELF_REINIT_LEN(2)) i_ohci_host_control_registers (.*);
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        if (w) begin
            {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
        end else begin
            {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        end
        for (n = 0; n < 64; n++) begin
            @(posedge ref_clk);
            if (s_axi_bvalid || s_axi_rvalid) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        {rdVal, rdResp} = {s_axi_rdata, s_axi_rresp};
        errTotal += (n == 64);
        if (n == 64) report_and_stop;
    endtask
    task automatic ck(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp(rdVal, exp);
    endtask
    task automatic t_bus;
        ck(OFF_CTRL_CLR, 32'h0080_0000);
        bus(1'b1, OFF_VENDOR, 32'hFFFF_FFFF);
        ck(OFF_VENDOR, 32'h0000_0000);
        bus(1'b1, OFF_CTRL_SET, 32'hFFFE_FFFF);
        ck(OFF_CTRL_CLR, 32'hE0CE_0000);
        bus(1'b1, OFF_CTRL_CLR, 32'h4080_0000);
        bus(1'b1, OFF_CTRL_SET, 32'h0080_0000);
        ck(OFF_CTRL_SET, 32'hA04E_0000);
        cmp({24'h0, romAutoUpdateEnable, enhancementOwner, swapEnable, phyPowerRequest,
            nodeActive, enhancementEnable, earlyWriteAccept, delayedAckPermit}, 32'hBF);
        bus(1'b1, OFF_CHAN_SET, 32'hFFFF_0000);
        bus(1'b1, OFF_CHAN_CLR, 32'h0F00_0000);
        ck(OFF_CHAN_CLR, 32'hF0FF_0000);
        cmp(upperChannelEnable, 32'hF0FF_0000);
        bus(1'b1, OFF_BUF_PTR, 32'hFFFF_FFFF);
        ck(OFF_BUF_PTR, 32'hFFFF_F800);
        cmp(nodeIdBufferAddr, 32'hFFFF_F800);
        ck(8'hFC, 32'h0);
        cmp({30'h0, rdResp}, 32'h2);
        $display("bus test done");
    endtask
    task automatic t_link;
        bus(1'b1, OFF_ROM_MAP, 32'hFFFF_FFFF);
        ck(OFF_ROM_MAP, 32'hFFFF_FC00);
        {romQuadReq, romBlockReq, romQuadOffset} <= {2'h3, 48'hFFFF_F000_0404};
        {postedFailValid, busResetSeen, selfIdDone, pciUidWrite} <= 4'hF;
        {postedFail, selfIdResult} <= {16'h1234, 48'hABCD_0123_4567, 1'b1, 9'h005};
        pciUidValue <= 32'h2468_ACE0;
        @(posedge ref_clk);
        {romQuadReq, romBlockReq, postedFailValid, busResetSeen, selfIdDone} <= 5'h0;
        pciUidValue <= 32'h0;
        @(posedge ref_clk);
        pciUidWrite <= 1'b0;
        @(posedge ref_clk);
        cmp(romHostAddr, 32'hFFFF_FC04);
        ck(OFF_FAIL_LOW, 32'h0123_4567);
        ck(OFF_FAIL_HIGH, 32'h1234_ABCD);
        ck(OFF_TALLY, 32'h8001_0014);
        ck(OFF_UID_LOW, 32'h1357_9BDF);
        cmp(uniqueIdLow, 32'h1357_9BDF);
        bus(1'b1, OFF_CTRL_CLR, 32'h8000_0000);
        romBlockReq <= 1'b1;
        @(posedge ref_clk);
        romBlockReq <= 1'b0;
        $display("link test done");
    endtask
    task automatic t_reinit;
        bus(1'b1, OFF_CTRL_SET, 32'h0001_0000);
        repeat (4) @(posedge ref_clk);
        ck(OFF_CTRL_SET, 32'h0000_0000);
        ck(OFF_CHAN_SET, 32'h0000_0000);
        {pciOwnerLoad, pciOwnerValue} <= 2'h3;
        @(posedge ref_clk);
        pciOwnerLoad <= 1'b0;
        ck(OFF_CTRL_SET, 32'h0080_0000);
        romQuadReq <= 1'b1;
        @(posedge ref_clk);
        romQuadReq <= 1'b0;
        $display("reinit test done");
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, romQuadReq, romBlockReq} = 5'h0;
        {postedFailValid, busResetSeen, selfIdDone, pciOwnerLoad, pciOwnerValue} = 5'h0;
        // Ready lines held high: legal, and saves a handshake turn
        {pciUidWrite, s_axi_bready, s_axi_rready, sys_rst} = 4'h7;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pciUidValue} = '0;
        {romQuadOffset, postedFail, selfIdResult} = '0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Id loaded before the node is enabled
        {pciUidWrite, pciUidValue} <= {1'b1, 32'h1357_9BDF};
        @(posedge ref_clk);
        t_bus;
        t_link;
        t_reinit;
        report_and_stop;
    end
endmodule
